// file: hw/ata_host_cfg.svh
`ifndef ATA_HOST_CFG_SVH
`define ATA_HOST_CFG_SVH

// clock
`define CLK_PERIOD_NS 10

// timing: least times round up to whole cycles
`define BUS_RESET_MIN_NS 25000
`define BUS_RESET_CYCLES ((`BUS_RESET_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CHIP_RESET_NS 1000
`define CHIP_RESET_CYCLES ((`CHIP_RESET_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// register byte offsets
`define CTRL_OFS 8'h00
`define CMD_OFS 8'h04
`define STATUS_OFS 8'h08
`define ERR_OFS 8'h0c
`define STRAP_OFS 8'h10

// control register fields
`define CTRL_TOPO_LSB 0
`define CTRL_TOPO_MSB 1
`define CTRL_SLAVE_BIT 2
`define CTRL_ATA_SET_BIT 3
`define CTRL_OPTICAL_BIT 4
`define CTRL_IRQ_EN_BIT 5
`define CTRL_BUS_RST_EN_BIT 6
`define CTRL_WIDTH 7
`define CTRL_RESET 7'h40

// command register fields (write only, self clearing)
`define CMD_BUS_RST_BIT 0
`define CMD_CHIP_RST_BIT 1

// status register fields
`define STAT_IRQ_BIT 0
`define STAT_BUS_BUSY_BIT 1
`define STAT_CHIP_BUSY_BIT 2
`define STAT_CD_A_BIT 3
`define STAT_CD_B_BIT 4

// sticky error register fields, write one to clear
`define ERR_UNSUP_BIT 0
`define ERR_DEVS_BIT 1
`define ERR_HUBS_BIT 2
`define ERR_CD_CHG_BIT 3
`define ERR_WIDTH 4
`define ERR_RESET 4'h0

// strap readback fields
`define STRAP_BUS_TYPE_BIT 0
`define STRAP_CMD_SET_BIT 1
`define STRAP_COUNT_BIT 2
`define STRAP_SELECT_BIT 3

// strap encodings
`define STRAP_IDE 1'b0
`define STRAP_CPU 1'b1
`define STRAP_ATAPI 1'b0
`define STRAP_ATA 1'b1
`define STRAP_SINGLE 1'b0
`define STRAP_TWO 1'b1
`define STRAP_MASTER 1'b0
`define STRAP_SLAVE 1'b1

`endif

// file: hw/ata_host_pkg.sv
package ata_host_pkg;

    typedef enum logic [1:0] {
        TOPO_PC_IDE = 2'b00,
        TOPO_IDE_ALONE = 2'b01,
        TOPO_IDE_SHARED = 2'b10,
        TOPO_CPU_BUS = 2'b11
    } topo_e;

    typedef enum logic [2:0] {
        SEL_NONE = 3'b000,
        SEL_CTRL = 3'b001,
        SEL_CMD = 3'b010,
        SEL_STATUS = 3'b011,
        SEL_ERR = 3'b100,
        SEL_STRAP = 3'b101
    } reg_sel_e;

    typedef enum logic {
        PULSE_IDLE = 1'b0,
        PULSE_HOLD = 1'b1
    } pulse_state_e;

endpackage : ata_host_pkg

// file: hw/reset_pulser.sv
module reset_pulser #(
    parameter int unsigned HOLD_CYCLES = 2500,
    parameter int unsigned CW = $clog2(HOLD_CYCLES + 1)
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic start,
    output logic rst_n_out,
    output logic busy
);
    ata_host_pkg::pulse_state_e state_ff;
    ata_host_pkg::pulse_state_e nxt_state;
    logic [CW-1:0] cnt_ff;
    logic [CW-1:0] nxt_cnt;
    logic rst_n_ff;
    logic nxt_rst_n;

    wire logic last = (cnt_ff == '0);

    // low for exactly HOLD_CYCLES edges; starts ignored while holding
    always_comb begin
        nxt_state = state_ff;
        nxt_cnt = cnt_ff;
        nxt_rst_n = rst_n_ff;
        unique case (state_ff)
            ata_host_pkg::PULSE_IDLE: begin
                if (start) begin
                    nxt_state = ata_host_pkg::PULSE_HOLD;
                    nxt_cnt = CW'(HOLD_CYCLES - 1);
                    nxt_rst_n = 1'b0;
                end
            end
            ata_host_pkg::PULSE_HOLD: begin
                if (last) begin
                    nxt_state = ata_host_pkg::PULSE_IDLE;
                    nxt_rst_n = 1'b1;
                end else begin
                    nxt_cnt = cnt_ff - CW'(1);
                end
            end
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_ff <= ata_host_pkg::PULSE_IDLE;
            cnt_ff <= '0;
            rst_n_ff <= 1'b1;
        end else begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
            rst_n_ff <= nxt_rst_n;
        end
    end

    assign rst_n_out = rst_n_ff;
    assign busy = (state_ff == ata_host_pkg::PULSE_HOLD);

endmodule : reset_pulser

// file: hw/ata_host_port_config.sv
// Contract
// R01 - PC IDE port: bus type IDE, ATAPI command set, single-device mode, all straps low; code drives drive select high when the slave bit is set.
// R02 - drive select low means master, high means slave on the shared bus.
// R03 - sole target on IDE bus: two-device mode and master select.
// R04 - other IDE device shares bus: single-device mode, select master or slave.
// R05 - CPU memory bus: same as sole IDE target, two-device mode, master.
// R06 - device interrupt output carries standard INTRQ meaning, active low.
// R07 - host treats the device interrupt as a level, not an edge.
// R08 - polling host may ignore the interrupt output entirely.
// R09 - bus reset aborts any command in progress, like standard hardware reset.
// R10 - host holds bus reset asserted at least 25 microseconds.
// R11 - bus reset keeps microcode loaded by DOWNLOAD MICROCODE.
// R12 - unused bus reset is held permanently high.
// R13 - bus reset differs from chip reset; no full chip reset.
// R14 - card-detect outputs unchanged on compliance errors.
// R15 - USB vendor and product ids never exposed; identify responses only.
// R16 - optical drive needs ATAPI; flash or disk may use either set.
// R17 - CPU mode and IDE mode share one bus interface and timing.
// R18 - device can refuse peripherals not on its permitted device list.
// R19 - device never forces high-speed peripheral to full speed itself.
// R20 - third or later storage device raises excess-devices error.
// R21 - straps sampled during chip reset and static afterwards.
`include "ata_host_cfg.svh"

module ata_host_port_config #(
    parameter int unsigned BUS_RESET_CYCLES = `BUS_RESET_CYCLES,
    parameter int unsigned CHIP_RESET_CYCLES = `CHIP_RESET_CYCLES
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    output logic host_bus_type_strap,
    output logic command_set_strap,
    output logic device_count_strap,
    output logic drive_select_strap,
    output logic chip_reset_n,
    output logic host_bus_reset_n,
    input wire logic host_interrupt_n,
    input wire logic card_detect_out_a,
    input wire logic card_detect_out_b,
    input wire logic error_port_unsupported,
    input wire logic error_port_excess_devices,
    input wire logic error_port_excess_hubs,
    output logic host_irq
);

    function automatic ata_host_pkg::reg_sel_e reg_decode(input logic [7:0] ofs);
        ata_host_pkg::reg_sel_e sel;
        sel = ata_host_pkg::SEL_NONE;
        if (ofs == `CTRL_OFS) sel = ata_host_pkg::SEL_CTRL;
        if (ofs == `CMD_OFS) sel = ata_host_pkg::SEL_CMD;
        if (ofs == `STATUS_OFS) sel = ata_host_pkg::SEL_STATUS;
        if (ofs == `ERR_OFS) sel = ata_host_pkg::SEL_ERR;
        if (ofs == `STRAP_OFS) sel = ata_host_pkg::SEL_STRAP;
        return sel;
    endfunction : reg_decode

    // ---------------- bus slave ----------------
    logic wr_pend_ff;
    ata_host_pkg::reg_sel_e wr_sel_ff;
    logic [31:0] rdata_ff;
    logic [31:0] nxt_rdata;

    wire logic addr_go = hsel & htrans[1] & hready;
    wire ata_host_pkg::reg_sel_e addr_sel = reg_decode(haddr[7:0]);
    wire logic wr_ctrl = wr_pend_ff & (wr_sel_ff == ata_host_pkg::SEL_CTRL);
    wire logic wr_cmd = wr_pend_ff & (wr_sel_ff == ata_host_pkg::SEL_CMD);
    wire logic wr_err = wr_pend_ff & (wr_sel_ff == ata_host_pkg::SEL_ERR);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_ff <= 1'b0;
            wr_sel_ff <= ata_host_pkg::SEL_NONE;
            rdata_ff <= 32'h0000_0000;
        end else begin
            wr_pend_ff <= addr_go & hwrite;
            wr_sel_ff <= addr_sel;
            rdata_ff <= nxt_rdata;
        end
    end

    // zero wait states, always OKAY
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = rdata_ff;

    // ---------------- control register ----------------
    logic [`CTRL_WIDTH-1:0] ctrl_ff;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_ff <= `CTRL_RESET;
        end else if (wr_ctrl) begin
            ctrl_ff <= hwdata[`CTRL_WIDTH-1:0];
        end
    end

    wire ata_host_pkg::topo_e topo = ata_host_pkg::topo_e'(ctrl_ff[`CTRL_TOPO_MSB:`CTRL_TOPO_LSB]);
    wire logic want_slave = ctrl_ff[`CTRL_SLAVE_BIT];
    wire logic want_ata = ctrl_ff[`CTRL_ATA_SET_BIT];
    wire logic optical = ctrl_ff[`CTRL_OPTICAL_BIT];
    wire logic irq_en = ctrl_ff[`CTRL_IRQ_EN_BIT];
    wire logic bus_rst_en = ctrl_ff[`CTRL_BUS_RST_EN_BIT];

    // ---------------- strap derivation ----------------
    wire logic is_pc = (topo == ata_host_pkg::TOPO_PC_IDE);
    wire logic is_alone = (topo == ata_host_pkg::TOPO_IDE_ALONE);
    wire logic is_shared = (topo == ata_host_pkg::TOPO_IDE_SHARED);
    wire logic is_cpu = (topo == ata_host_pkg::TOPO_CPU_BUS);

    wire logic want_bus_type = is_cpu ? `STRAP_CPU : `STRAP_IDE; // R01 R05
    // pc port always ATAPI; optical drive forces ATAPI
    wire logic want_cmd_set = (is_pc | optical) ? `STRAP_ATAPI : want_ata; // R01 R16
    wire logic want_count = (is_alone | is_cpu) ? `STRAP_TWO : `STRAP_SINGLE; // R01 R03 R04 R05
    // slave only where another device can own the master role
    wire logic want_select = ((is_pc | is_shared) & want_slave) ? `STRAP_SLAVE : `STRAP_MASTER; // R02 R03 R05

    // ---------------- reset sequencing ----------------
    logic boot_ff;
    logic bus_busy;
    logic chip_busy;
    logic bus_rst_n_raw;

    // chip reset once after our own reset so the straps get sampled
    wire logic chip_start = (boot_ff | (wr_cmd & hwdata[`CMD_CHIP_RST_BIT])) & ~chip_busy;
    // gated start keeps the pin high for good when bus reset is unused
    wire logic bus_start = wr_cmd & hwdata[`CMD_BUS_RST_BIT] & bus_rst_en & ~bus_busy; // R12

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            boot_ff <= 1'b1;
        end else if (!chip_busy) begin
            boot_ff <= 1'b0;
        end
    end

    reset_pulser #(
        .HOLD_CYCLES(BUS_RESET_CYCLES)
    ) u_bus_rst (
        .hclk(hclk),
        .hresetn(hresetn),
        .start(bus_start),
        .rst_n_out(bus_rst_n_raw),
        .busy(bus_busy)
    ); // R10

    reset_pulser #(
        .HOLD_CYCLES(CHIP_RESET_CYCLES)
    ) u_chip_rst (
        .hclk(hclk),
        .hresetn(hresetn),
        .start(chip_start),
        .rst_n_out(chip_reset_n),
        .busy(chip_busy)
    );

    assign host_bus_reset_n = bus_rst_n_raw;

    // straps change only on the edge that enters chip reset
    logic bus_type_ff;
    logic cmd_set_ff;
    logic count_ff;
    logic select_ff;
    logic applied_optical_ff;
    ata_host_pkg::topo_e applied_topo_ff;
    logic applied_slave_ff;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bus_type_ff <= `STRAP_IDE;
            cmd_set_ff <= `STRAP_ATAPI;
            count_ff <= `STRAP_SINGLE;
            select_ff <= `STRAP_MASTER;
            applied_optical_ff <= 1'b0;
            applied_topo_ff <= ata_host_pkg::TOPO_PC_IDE;
            applied_slave_ff <= 1'b0;
        end else if (chip_start) begin // R21
            bus_type_ff <= want_bus_type;
            cmd_set_ff <= want_cmd_set;
            count_ff <= want_count;
            select_ff <= want_select;
            applied_optical_ff <= optical;
            applied_topo_ff <= topo;
            applied_slave_ff <= want_slave;
        end
    end

    assign host_bus_type_strap = bus_type_ff;
    assign command_set_strap = cmd_set_ff;
    assign device_count_strap = count_ff;
    assign drive_select_strap = select_ff;

    // ---------------- interrupt level and status ----------------
    logic irq_ff;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= irq_en & ~host_interrupt_n; // R07 R08
        end
    end

    // level follows the pin; no latch, so service must clear the cause
    assign host_irq = irq_ff;

    logic [`ERR_WIDTH-1:0] err_ff;
    logic cd_a_ff;
    logic cd_b_ff;

    wire logic cd_change = (cd_a_ff != card_detect_out_a) | (cd_b_ff != card_detect_out_b);
    wire logic [`ERR_WIDTH-1:0] err_set = {cd_change, error_port_excess_hubs, error_port_excess_devices,
        error_port_unsupported};
    wire logic [`ERR_WIDTH-1:0] err_clr = wr_err ? hwdata[`ERR_WIDTH-1:0] : '0;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            err_ff <= `ERR_RESET;
            cd_a_ff <= 1'b0;
            cd_b_ff <= 1'b0;
        end else begin
            // a new event outranks a clear in the same cycle
            err_ff <= (err_ff & ~err_clr) | err_set;
            cd_a_ff <= card_detect_out_a;
            cd_b_ff <= card_detect_out_b;
        end
    end

    // ---------------- read mux ----------------
    wire logic [31:0] status_word = 32'h0000_0000
        | (32'(irq_ff) << `STAT_IRQ_BIT)
        | (32'(bus_busy) << `STAT_BUS_BUSY_BIT)
        | (32'(chip_busy) << `STAT_CHIP_BUSY_BIT)
        | (32'(cd_a_ff) << `STAT_CD_A_BIT)
        | (32'(cd_b_ff) << `STAT_CD_B_BIT);
    wire logic [31:0] strap_word = 32'h0000_0000
        | (32'(bus_type_ff) << `STRAP_BUS_TYPE_BIT)
        | (32'(cmd_set_ff) << `STRAP_CMD_SET_BIT)
        | (32'(count_ff) << `STRAP_COUNT_BIT)
        | (32'(select_ff) << `STRAP_SELECT_BIT);

    always_comb begin
        nxt_rdata = rdata_ff;
        if (addr_go & ~hwrite) begin
            unique case (addr_sel)
                ata_host_pkg::SEL_CTRL: nxt_rdata = 32'(ctrl_ff);
                ata_host_pkg::SEL_STATUS: nxt_rdata = status_word;
                ata_host_pkg::SEL_ERR: nxt_rdata = 32'(err_ff);
                ata_host_pkg::SEL_STRAP: nxt_rdata = strap_word;
                default: nxt_rdata = 32'h0000_0000;
            endcase
        end
    end

    // ---------------- checks ----------------
    logic [15:0] low_cnt_ff;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            low_cnt_ff <= 16'h0000;
        end else if (!host_bus_reset_n) begin
            low_cnt_ff <= low_cnt_ff + 16'h0001;
        end else begin
            low_cnt_ff <= 16'h0000;
        end
    end

    property p_pc_straps;
        @(posedge hclk) disable iff (!hresetn)
        (applied_topo_ff == ata_host_pkg::TOPO_PC_IDE) |->
            (!host_bus_type_strap && !command_set_strap && !device_count_strap);
    endproperty
    a_pc_straps: assert property (p_pc_straps) else $error("pc port straps not all low"); // R01

    property p_select;
        @(posedge hclk) disable iff (!hresetn)
        $changed(drive_select_strap) |->
            (drive_select_strap == (applied_slave_ff && (applied_topo_ff == ata_host_pkg::TOPO_PC_IDE
            || applied_topo_ff == ata_host_pkg::TOPO_IDE_SHARED)));
    endproperty
    a_select: assert property (p_select) else $error("drive select strap wrong role"); // R02

    property p_alone;
        @(posedge hclk) disable iff (!hresetn)
        (applied_topo_ff == ata_host_pkg::TOPO_IDE_ALONE) |->
            (device_count_strap && !drive_select_strap && !host_bus_type_strap);
    endproperty
    a_alone: assert property (p_alone) else $error("sole ide target not two-device master"); // R03

    property p_shared;
        @(posedge hclk) disable iff (!hresetn)
        (applied_topo_ff == ata_host_pkg::TOPO_IDE_SHARED) |-> !device_count_strap;
    endproperty
    a_shared: assert property (p_shared) else $error("shared bus not single-device mode"); // R04

    property p_cpu;
        @(posedge hclk) disable iff (!hresetn)
        (applied_topo_ff == ata_host_pkg::TOPO_CPU_BUS) |->
            (host_bus_type_strap && device_count_strap && !drive_select_strap);
    endproperty
    a_cpu: assert property (p_cpu) else $error("cpu bus straps wrong"); // R05

    property p_irq_level;
        @(posedge hclk) disable iff (!hresetn)
        (irq_en && !host_interrupt_n) [*3] |-> host_irq ##1 (host_irq || host_interrupt_n || !irq_en);
    endproperty
    a_irq_level: assert property (p_irq_level) else $error("held interrupt level not reported"); // R07

    property p_irq_off;
        @(posedge hclk) disable iff (!hresetn)
        (!irq_en || host_interrupt_n) |=> !host_irq;
    endproperty
    a_irq_off: assert property (p_irq_off) else $error("interrupt raised while unused or idle"); // R08

    property p_bus_reset_min;
        @(posedge hclk) disable iff (!hresetn)
        $rose(host_bus_reset_n) |-> ($past(low_cnt_ff) >= 16'(BUS_RESET_CYCLES - 1));
    endproperty
    a_bus_reset_min: assert property (p_bus_reset_min) else $error("bus reset released too early"); // R10

    property p_bus_reset_unused;
        @(posedge hclk) disable iff (!hresetn)
        (!bus_rst_en && !bus_busy) |=> host_bus_reset_n;
    endproperty
    a_bus_reset_unused: assert property (p_bus_reset_unused) else $error("unused bus reset driven"); // R12

    property p_optical;
        @(posedge hclk) disable iff (!hresetn)
        applied_optical_ff |-> (command_set_strap == `STRAP_ATAPI);
    endproperty
    a_optical: assert property (p_optical) else $error("optical drive without atapi"); // R16

    property p_static_straps;
        @(posedge hclk) disable iff (!hresetn)
        ($changed(host_bus_type_strap) || $changed(command_set_strap) || $changed(device_count_strap)
            || $changed(drive_select_strap)) |-> !chip_reset_n;
    endproperty
    a_static_straps: assert property (p_static_straps) else $error("strap moved outside chip reset"); // R21

    c_bus_reset: cover property (@(posedge hclk) disable iff (!hresetn) $rose(host_bus_reset_n));
    c_chip_apply: cover property (@(posedge hclk) disable iff (!hresetn) chip_start && !boot_ff);
    c_irq: cover property (@(posedge hclk) disable iff (!hresetn) $rose(host_irq));
    c_err_clear: cover property (@(posedge hclk) disable iff (!hresetn) wr_err && (err_ff != '0));

endmodule : ata_host_port_config

// file: sim/ata_dev_model.sv
module ata_dev_model (
    input wire logic hclk,
    input wire logic chip_reset_n,
    input wire logic host_bus_reset_n,
    input wire logic [3:0] straps,
    input wire logic cmd_go,
    input wire logic mcode_load,
    input wire logic unsup_req,
    input wire logic hubs_req,
    input wire logic [2:0] storage_count,
    output logic host_interrupt_n,
    output logic card_detect_out_a,
    output logic card_detect_out_b,
    output logic error_port_unsupported,
    output logic error_port_excess_devices,
    output logic error_port_excess_hubs,
    output logic [3:0] latched_ff,
    output logic mcode_ff
);
    timeunit 1ns;
    timeprecision 1ps;
    logic irq_ff;
    logic busy_ff;
    logic [1:0] wait_ff;
    // straps are ignored once the chip leaves reset
    always @(posedge hclk) begin
        if (!chip_reset_n) begin
            latched_ff <= straps;
        end
    end
    always @(posedge hclk or negedge chip_reset_n or negedge host_bus_reset_n) begin
        if (!chip_reset_n || !host_bus_reset_n) begin
            busy_ff <= 1'b0;
            irq_ff <= 1'b0;
            wait_ff <= 2'h0;
            if (!chip_reset_n) begin
                mcode_ff <= 1'b0;
            end
        end else begin
            if (mcode_load) begin
                mcode_ff <= 1'b1;
            end
            if (cmd_go) begin
                busy_ff <= 1'b1;
                irq_ff <= 1'b0;
                wait_ff <= 2'h3;
            end else if (busy_ff) begin
                wait_ff <= wait_ff - 2'h1;
                if (wait_ff == 2'h0) begin
                    busy_ff <= 1'b0;
                    irq_ff <= 1'b1;
                end
            end
        end
    end
    // only a status level leaves the model, never any usb identity
    assign host_interrupt_n = !irq_ff;
    assign card_detect_out_a = storage_count >= 3'h1;
    assign card_detect_out_b = storage_count >= 3'h2;
    assign error_port_excess_devices = storage_count >= 3'h3;
    assign error_port_unsupported = unsup_req;
    assign error_port_excess_hubs = hubs_req;
endmodule : ata_dev_model

// file: sim/tb.sv
`include "ata_host_cfg.svh"
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int unsigned BRC = 8;
    localparam int unsigned CRC = 4;
    logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, host_irq;
    logic [31:0] haddr, hwdata, hrdata, rd, ctl;
    logic [1:0] htrans;
    logic [2:0] hsize, storage_count;
    logic bus_t, cmd_s, cnt_s, sel_s, chip_rst_n, bus_rst_n, int_n, cd_a, cd_b, e_un, e_dev, e_hub;
    logic cmd_go, mcode_load, unsup_req, hubs_req, mcode;
    logic [3:0] latched, pins, e, prev;
    int err_count, n_checks, n, k;
    assign hready = hreadyout;
    assign pins = {sel_s, cnt_s, cmd_s, bus_t};
    ata_host_port_config #(.BUS_RESET_CYCLES(BRC), .CHIP_RESET_CYCLES(CRC)) u_dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .host_bus_type_strap(bus_t), .command_set_strap(cmd_s), .device_count_strap(cnt_s),
        .drive_select_strap(sel_s), .chip_reset_n(chip_rst_n), .host_bus_reset_n(bus_rst_n),
        .host_interrupt_n(int_n), .card_detect_out_a(cd_a), .card_detect_out_b(cd_b),
        .error_port_unsupported(e_un), .error_port_excess_devices(e_dev),
        .error_port_excess_hubs(e_hub), .host_irq(host_irq)
    );
    ata_dev_model u_dev (
        .hclk(hclk), .chip_reset_n(chip_rst_n), .host_bus_reset_n(bus_rst_n), .straps(pins),
        .cmd_go(cmd_go), .mcode_load(mcode_load), .unsup_req(unsup_req), .hubs_req(hubs_req),
        .storage_count(storage_count), .host_interrupt_n(int_n), .card_detect_out_a(cd_a),
        .card_detect_out_b(cd_b), .error_port_unsupported(e_un), .error_port_excess_devices(e_dev),
        .error_port_excess_hubs(e_hub), .latched_ff(latched), .mcode_ff(mcode)
    );
    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end
    task give_verdict;
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : give_verdict
    task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk
    task wait_ready;
        int j;
        j = 0;
        do begin
            @(posedge hclk);
            j++;
        end while (hready !== 1'b1 && j < 50);
        if (j >= 50) begin
            err_count++;
            give_verdict;
        end
    endtask : wait_ready
    // one whole-word transfer; read data lands in rd
    task ahb_xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= wr;
        haddr <= {24'h0, a};
        wait_ready;
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        wait_ready;
        rd = hrdata;
    endtask : ahb_xfer
    // entered right after the edge that launches the pulse
    task count_low(input logic chip, output int cnt);
        #1;
        cnt = 0;
        while ((chip ? chip_rst_n : bus_rst_n) === 1'b0 && cnt < 200) begin
            @(posedge hclk);
            #1;
            cnt++;
        end
        if (cnt >= 200) begin
            err_count++;
            give_verdict;
        end
    endtask : count_low
    function automatic logic [3:0] exp_straps(input logic [1:0] t, input logic sl, input logic ata,
                                              input logic opt);
        logic c;
        c = (t == 2'h0 || opt) ? 1'b0 : ata;
        return {(t == 2'h0 || t == 2'h2) & sl, t[0], c, t == 2'h3};
    endfunction : exp_straps
    initial begin
        #1000000;
        err_count++;
        give_verdict;
    end
    initial begin
        hresetn = 1'b0;
        {hsel, hwrite, cmd_go, mcode_load, unsup_req, hubs_req} = 6'h0;
        htrans = 2'h0;
        hsize = 3'h2;
        haddr = 32'h0;
        hwdata = 32'h0;
        storage_count = 3'h0;
        err_count = 0;
        n_checks = 0;
        prev = 4'h0;
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        count_low(1'b1, n);
        chk(32'(n), CRC, "boot chip reset");
        ahb_xfer(1'b0, `CTRL_OFS, 32'h0);
        chk(rd, 32'h40, "ctrl reset");
        chk(32'(hresp), 32'h0, "okay response");
        ahb_xfer(1'b0, `STRAP_OFS, 32'h0);
        chk(rd, 32'h0, "strap reset");
        chk(32'(latched), 32'h0, "device straps");
        ahb_xfer(1'b1, 8'h14, 32'hffffffff);
        ahb_xfer(1'b0, 8'h14, 32'h0);
        chk(rd, 32'h0, "unmapped");
        ahb_xfer(1'b0, `CMD_OFS, 32'h0);
        chk(rd, 32'h0, "cmd read");
        $display("test reset done");
        for (int t = 0; t < 5; t++) begin
            ctl = (t == 4) ? 32'h5d : (32'h4c | t);
            ahb_xfer(1'b1, `CTRL_OFS, ctl);
            chk(32'(pins), 32'(prev), "straps before chip reset");
            ahb_xfer(1'b1, `CMD_OFS, 32'h2);
            count_low(1'b1, n);
            chk(32'(n), CRC, "chip reset length");
            e = exp_straps(ctl[1:0], 1'b1, 1'b1, ctl[4]);
            chk(32'(pins), 32'(e), "strap pins");
            ahb_xfer(1'b0, `STRAP_OFS, 32'h0);
            chk(rd, 32'(e), "strap readback");
            chk(32'(latched), 32'(e), "device straps");
            prev = e;
        end
        $display("test straps done");
        ahb_xfer(1'b1, `CTRL_OFS, 32'h60);
        @(posedge hclk);
        mcode_load <= 1'b1;
        cmd_go <= 1'b1;
        @(posedge hclk);
        mcode_load <= 1'b0;
        cmd_go <= 1'b0;
        k = 0;
        while (int_n !== 1'b0 && k < 20) begin
            @(posedge hclk);
            k++;
        end
        repeat (2) @(posedge hclk);
        #1;
        chk(32'(host_irq), 32'h1, "irq raised");
        ahb_xfer(1'b0, `STATUS_OFS, 32'h0);
        chk(32'(rd[0]), 32'h1, "status irq");
        ahb_xfer(1'b1, `CTRL_OFS, 32'h40);
        repeat (2) @(posedge hclk);
        #1;
        chk(32'(host_irq), 32'h0, "irq masked");
        ahb_xfer(1'b1, `CTRL_OFS, 32'h60);
        repeat (2) @(posedge hclk);
        #1;
        chk(32'(host_irq), 32'h1, "level irq seen again");
        ahb_xfer(1'b1, `CMD_OFS, 32'h1);
        count_low(1'b0, n);
        chk(32'(n), BRC, "bus reset length");
        repeat (2) @(posedge hclk);
        #1;
        chk(32'(host_irq), 32'h0, "irq after abort");
        chk(32'(mcode), 32'h1, "microcode kept");
        chk(32'(chip_rst_n), 32'h1, "no chip reset");
        chk(32'(latched), 32'(prev), "straps kept");
        ahb_xfer(1'b1, `CMD_OFS, 32'h1);
        ahb_xfer(1'b0, `STATUS_OFS, 32'h0);
        chk(32'(rd[1]), 32'h1, "bus reset busy");
        count_low(1'b0, n);
        ahb_xfer(1'b1, `CTRL_OFS, 32'h20);
        ahb_xfer(1'b1, `CMD_OFS, 32'h1);
        repeat (3) @(posedge hclk);
        #1;
        chk(32'(bus_rst_n), 32'h1, "unused bus reset high");
        $display("test irq and bus reset done");
        @(posedge hclk);
        storage_count <= 3'h2;
        ahb_xfer(1'b1, `ERR_OFS, 32'hf);
        ahb_xfer(1'b0, `ERR_OFS, 32'h0);
        chk(rd, 32'h0, "errors cleared");
        @(posedge hclk);
        unsup_req <= 1'b1;
        hubs_req <= 1'b1;
        storage_count <= 3'h3;
        @(posedge hclk);
        unsup_req <= 1'b0;
        hubs_req <= 1'b0;
        ahb_xfer(1'b0, `ERR_OFS, 32'h0);
        chk(rd, 32'h7, "sticky errors");
        ahb_xfer(1'b0, `STATUS_OFS, 32'h0);
        chk(32'(rd[4:3]), 32'h3, "card detect kept");
        ahb_xfer(1'b1, `ERR_OFS, 32'h1);
        ahb_xfer(1'b0, `ERR_OFS, 32'h0);
        chk(rd, 32'h6, "clear one");
        ahb_xfer(1'b1, `ERR_OFS, 32'h4);
        ahb_xfer(1'b0, `ERR_OFS, 32'h0);
        chk(rd, 32'h2, "excess devices held");
        $display("test errors done");
        give_verdict;
    end
endmodule : tb
